// [ineap_top.sv]
// I2C slave with NVM page program, page erase and write protection.
`timescale 1ns/1ps
module ineap_top #(
  parameter int WR_CYC = ineap_pkg::WR_CYCLES
) (
  input logic mclk,
  input logic reset_n,
  input logic scl_in,
  input logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input logic [ineap_pkg::CODE_W-1:0] ctrl_code_pins,
  input logic soft_reset,
  output logic nvm_busy
);
  import ineap_pkg::*;
  localparam int CW = $clog2(WR_CYC + 1);

  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [CODE_W+1:0] sync_q;
  logic scl_s;
  logic sda_s;
  logic [CODE_W-1:0] pin_s;
  logic scl_d_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  ineap_state_t st_ff;
  ineap_state_t nxt_st;
  logic [3:0] bitcnt_ff;
  logic ackph_ff;
  logic [7:0] shift_ff;
  logic [7:0] tx_ff;
  logic oe_ff;
  logic [2:0] blk_ff;
  logic [7:0] word_ff;
  logic [7:0] nxt_word;
  logic pend_ff;
  logic arm_ff;
  logic load_ff;

  logic busy_ff;
  logic [CW-1:0] cnt_ff;
  ineap_op_t op_ff;
  ineap_op_t nxt_op;
  logic [7:0] pbuf_ff [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pmask_ff;
  logic [7:0] reg_q [REG_BYTES];
  logic [7:0] nvm_q [NVM_BYTES];

  logic byte_done;
  ineap_ctrl_t cb;
  ineap_wpr_t eeprom_write_protect;
  logic lock;
  logic [7:0] ers;
  logic [CODE_W-1:0] csel;
  logic [CODE_W-1:0] eff_code;
  logic blk_ok;
  logic ctrl_hit;
  logic is_reg;
  logic is_page;
  logic in_wdata;
  logic ers_byte;
  logic frozen;
  logic reg_wr;
  logic page_wr;
  logic ack_now;
  logic [7:0] rd_byte;
  logic prog_start;
  logic ers_req;
  logic ers_start;
  logic ers_clr;
  logic start_op;
  logic op_done;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Bus lines idle high, so their synchronised copies reset high as well.
  ineap_sync #(
    .W(CODE_W + 2),
    .RST({{CODE_W{1'b0}}, 2'b11})
  ) u_sync (
    .clk(mclk),
    .rst_n(rst_n),
    .d({ctrl_code_pins, scl_in, sda_in}),
    .q(sync_q)
  );

  assign scl_s = sync_q[1];
  assign sda_s = sync_q[0];
  assign pin_s = sync_q[CODE_W+1:2];

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_ff;
  assign scl_fall = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  // Byte decode.
  assign byte_done = scl_fall & ~ackph_ff & (bitcnt_ff == BITS_PER_BYTE);
  assign cb = shift_ff;
  assign eeprom_write_protect = reg_q[WPR_ADDR];
  assign lock = reg_q[LOCK_ADDR][LOCK_BIT];
  assign ers = reg_q[ERS_ADDR];
  assign csel = reg_q[CSEL_ADDR][CSEL_LSB +: CODE_W];
  assign eff_code = (csel & pin_s) | (~csel & reg_q[CODE_ADDR][CODE_W-1:0]);
  // Page blocks refuse the control byte while the array is busy, so software can poll on the acknowledge.
  assign blk_ok = (cb.blk == BLK_REG) | (((cb.blk == BLK_CFG) | (cb.blk == BLK_EEP)) & ~busy_ff);
  assign ctrl_hit = (cb.code == eff_code) & blk_ok;
  assign is_reg = blk_ff == BLK_REG;
  assign is_page = (blk_ff == BLK_CFG) | (blk_ff == BLK_EEP);
  assign in_wdata = byte_done & (st_ff == ST_WDATA);
  assign ers_byte = is_reg & (word_ff == ERS_ADDR);
  assign frozen = lock & ((word_ff == WPR_ADDR) | (word_ff == LOCK_ADDR) | (word_ff == CSEL_ADDR));
  assign reg_wr = in_wdata & is_reg & ~frozen;
  assign page_wr = in_wdata & is_page;
  assign ack_now = ((st_ff == ST_CTRL) & ctrl_hit) | (st_ff == ST_WORD) | ((st_ff == ST_WDATA) & ~ers_byte);
  assign nxt_word = is_page ? {word_ff[7:4], word_ff[3:0] + 4'h1} : word_ff + 8'h01;
  assign rd_byte = is_reg ? reg_q[word_ff] :
                   (blk_ff == BLK_CFG) ? nvm_q[{SPACE_CFG, word_ff}] :
                   (blk_ff == BLK_EEP) ? nvm_q[{SPACE_EEP, word_ff}] : 8'h00;

  always_comb begin
    unique case (st_ff)
      ST_IDLE: begin
        nxt_st = ST_IDLE;
      end
      ST_CTRL: begin
        nxt_st = !ctrl_hit ? ST_IGNORE : (cb.rw ? ST_RDATA : ST_WORD);
      end
      ST_WORD: begin
        nxt_st = ST_WDATA;
      end
      ST_WDATA: begin
        nxt_st = ers_byte ? ST_IGNORE : ST_WDATA;
      end
      ST_RDATA: begin
        nxt_st = ST_RDATA;
      end
      ST_IGNORE: begin
        nxt_st = ST_IGNORE;
      end
      default: begin
        nxt_st = ST_IDLE;
      end
    endcase
  end

  // Bit engine: shift on SCL rise, drive the acknowledge or read data after SCL fall.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
      bitcnt_ff <= '0;
      ackph_ff <= 1'b0;
      shift_ff <= '0;
      tx_ff <= '0;
      oe_ff <= 1'b0;
    end else if (start_det) begin
      st_ff <= ST_CTRL;
      bitcnt_ff <= '0;
      ackph_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (stop_det || st_ff == ST_IDLE) begin
      st_ff <= ST_IDLE;
      ackph_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else if (scl_rise && !ackph_ff) begin
      shift_ff <= {shift_ff[6:0], sda_s};
      bitcnt_ff <= bitcnt_ff + 4'h1;
    end else if (scl_rise && st_ff == ST_RDATA && sda_s) begin
      st_ff <= ST_IGNORE;
    end else if (byte_done) begin
      ackph_ff <= 1'b1;
      oe_ff <= ack_now;
      st_ff <= nxt_st;
    end else if (scl_fall && ackph_ff) begin
      ackph_ff <= 1'b0;
      bitcnt_ff <= '0;
      oe_ff <= (st_ff == ST_RDATA) & ~rd_byte[BYTE_MSB];
      tx_ff <= rd_byte;
    end else if (scl_fall && st_ff == ST_RDATA) begin
      oe_ff <= ~tx_ff[3'(BYTE_MSB - int'(bitcnt_ff))];
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = oe_ff;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      blk_ff <= BLK_REG;
    end else if (byte_done && st_ff == ST_CTRL && ctrl_hit) begin
      blk_ff <= cb.blk;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      word_ff <= '0;
    end else if (byte_done && st_ff == ST_WORD) begin
      word_ff <= shift_ff;
    end else if (in_wdata) begin
      word_ff <= nxt_word;
    end else if (scl_fall && ackph_ff && st_ff == ST_RDATA) begin
      word_ff <= word_ff + 8'h01;
    end
  end

  // Pending page data and an armed erase live only until the next Start or the Stop that closes the write.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else if (start_det || stop_det) begin
      pend_ff <= 1'b0;
      arm_ff <= 1'b0;
    end else if (page_wr) begin
      pend_ff <= 1'b1;
    end else if (in_wdata && ers_byte) begin
      arm_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pmask_ff <= '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        pbuf_ff[i] <= 8'h00;
      end
    end else if (byte_done && st_ff == ST_WORD && is_page) begin
      pmask_ff <= '0;
    end else if (page_wr) begin
      pmask_ff[word_ff[3:0]] <= 1'b1;
      pbuf_ff[word_ff[3:0]] <= shift_ff;
    end
  end

  // Array cycle start, only at the Stop that ends the write.
  assign prog_start = stop_det & pend_ff & ~busy_ff & op_ok(blk_ff == BLK_EEP, word_ff[7:4], eeprom_write_protect, lock);
  assign ers_req = stop_det & arm_ff & ers[ERS_GO];
  assign ers_start = ers_req & ~busy_ff & op_ok(ers[ERS_SPACE], ers[3:0], eeprom_write_protect, lock);
  assign start_op = prog_start | ers_start;
  assign nxt_op = ers_start ? {1'b1, ers[ERS_SPACE], ers[3:0]} : {1'b0, blk_ff == BLK_EEP, word_ff[7:4]};
  assign op_done = busy_ff & (cnt_ff == '0);
  // A refused erase drops its go bit at once instead of waiting.
  assign ers_clr = (op_done & op_ff.erase) | (ers_req & ~ers_start);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      busy_ff <= 1'b0;
      cnt_ff <= '0;
      op_ff <= '0;
    end else if (start_op) begin
      busy_ff <= 1'b1;
      cnt_ff <= CW'(WR_CYC - 1);
      op_ff <= nxt_op;
    end else if (op_done) begin
      busy_ff <= 1'b0;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff - CW'(1);
    end
  end

  assign nvm_busy = busy_ff;

  // Working registers reload from the configuration pages after reset or soft reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      load_ff <= 1'b1;
    end else begin
      load_ff <= soft_reset;
    end
  end

  for (genvar g = 0; g < REG_BYTES; g++) begin : g_reg
    localparam logic [7:0] IDX = 8'(g);
    logic [7:0] q_ff;
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        q_ff <= 8'h00;
      end else if (load_ff) begin
        q_ff <= nvm_q[g];
      end else if (reg_wr && word_ff == IDX) begin
        q_ff <= shift_ff;
      end else if (ers_clr && IDX == ERS_ADDR) begin
        q_ff[ERS_GO] <= 1'b0;
      end
    end
    assign reg_q[g] = q_ff;
  end

  for (genvar g = 0; g < NVM_BYTES; g++) begin : g_nvm
    localparam logic [8:0] IDX = 9'(g);
    logic [7:0] q_ff;
    logic hit;
    assign hit = op_done & (IDX[8:4] == {op_ff.space, op_ff.page});
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        q_ff <= nvm_init(IDX);
      end else if (hit && op_ff.erase) begin
        q_ff <= 8'h00;
      end else if (hit && pmask_ff[IDX[3:0]]) begin
        q_ff <= q_ff | pbuf_ff[IDX[3:0]];
      end
    end
    assign nvm_q[g] = q_ff;
  end

  // Checks.
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [CW-1:0] age_ff;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      age_ff <= '0;
    end else if (start_op) begin
      age_ff <= '0;
    end else if (busy_ff) begin
      age_ff <= age_ff + CW'(1);
    end
  end

  a_ctrl_ack: assert property (byte_done && st_ff == ST_CTRL && ctrl_hit |=> oe_ff && ackph_ff)
    else $error("matching control byte not acknowledged");
  a_erase_irregular_ack: assert property (in_wdata && ers_byte |=> !oe_ff && st_ff == ST_IGNORE)
    else $error("erase data byte answered like a normal byte");
  a_start_at_stop: assert property ($rose(busy_ff) |-> $past(stop_det))
    else $error("array cycle started without a Stop");
  a_cycle_bound: assert property (busy_ff |-> age_ff < CW'(WR_CYC))
    else $error("array cycle overran its time");
  a_go_cleared: assert property (op_done && op_ff.erase |=> !reg_q[ERS_ADDR][ERS_GO] || $past(reg_wr))
    else $error("erase go bit not cleared after erase");
  a_unused_block_nack: assert property (byte_done && st_ff == ST_CTRL && !blk_ok |=> !oe_ff)
    else $error("unused block acknowledged");
  a_service_untouched: assert property (start_op |-> !(!nxt_op.space && nxt_op.page == SERVICE_PAGE))
    else $error("service page cycle started");
  a_region_respected: assert property (start_op && nxt_op.space && eeprom_write_protect.en |-> nxt_op.page[3:2] < ~eeprom_write_protect.region)
    else $error("protected EEPROM page cycle started");
  a_lock_freeze: assert property (lock && $past(lock) && !$past(load_ff) |-> $stable(reg_q[WPR_ADDR]))
    else $error("protect register changed while locked");
  a_reg_while_busy: assert property (busy_ff && byte_done && st_ff == ST_CTRL && cb.blk == BLK_REG
                                     && cb.code == eff_code |=> oe_ff)
    else $error("register block refused during array cycle");

  c_erase_done: cover property (op_done && op_ff.erase);
  c_prog_done: cover property (op_done && !op_ff.erase);
  c_read_byte: cover property (byte_done && st_ff == ST_RDATA);
  c_busy_nack: cover property (busy_ff && byte_done && st_ff == ST_CTRL && !blk_ok);
endmodule

// [ineap_pkg.sv]
// Constants, types and helper functions of the I2C NVM erase and protection block.
package ineap_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int T_WR_MS = 20;
  localparam int MS_PER_S = 1000;
  localparam int WR_CYCLES = T_WR_MS * (CLK_HZ / MS_PER_S);
  localparam int CODE_W = 4;
  localparam int BYTE_MSB = 7;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int PAGE_BYTES = 16;
  localparam int PAGES = 32;
  localparam int NVM_BYTES = PAGES * PAGE_BYTES;
  localparam int REG_BYTES = 256;
  localparam logic [2:0] BLK_REG = 3'h0;
  localparam logic [2:0] BLK_CFG = 3'h2;
  localparam logic [2:0] BLK_EEP = 3'h3;
  localparam logic SPACE_CFG = 1'b0;
  localparam logic SPACE_EEP = 1'b1;
  localparam logic [7:0] WPR_ADDR = 8'hE2;
  localparam logic [7:0] ERS_ADDR = 8'hE3;
  localparam logic [7:0] LOCK_ADDR = 8'hE4;
  localparam int LOCK_BIT = 0;
  localparam logic [7:0] CSEL_ADDR = 8'hCA;
  localparam int CSEL_LSB = 4;
  localparam logic [7:0] CODE_ADDR = 8'hCB;
  localparam logic [7:0] CODE_RST = 8'h01;
  localparam int ERS_GO = 7;
  localparam int ERS_SPACE = 4;
  localparam logic [3:0] PROT_PAGE = 4'hE;
  localparam logic [3:0] SERVICE_PAGE = 4'hF;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CTRL = 3'h1,
    ST_WORD = 3'h3,
    ST_WDATA = 3'h2,
    ST_RDATA = 3'h6,
    ST_IGNORE = 3'h7
  } ineap_state_t;

  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic [2:0] blk;
    logic rw;
  } ineap_ctrl_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic en;
    logic [1:0] region;
  } ineap_wpr_t;

  typedef struct packed {
    logic erase;
    logic space;
    logic [3:0] page;
  } ineap_op_t;

  // Region 00 covers pages 12..15, 01 pages 8..15, 10 pages 4..15, 11 all.
  function automatic logic prot_hit(input ineap_wpr_t w, input logic [3:0] pg);
    return w.en && (pg[3:2] >= ~w.region);
  endfunction

  function automatic logic op_ok(input logic eep, input logic [3:0] pg, input ineap_wpr_t w, input logic lk);
    if (eep) begin
      return !prot_hit(w, pg);
    end
    return (pg != SERVICE_PAGE) && !(lk && pg == PROT_PAGE);
  endfunction

  function automatic logic [7:0] nvm_init(input logic [8:0] idx);
    return (idx == {SPACE_CFG, CODE_ADDR}) ? CODE_RST : 8'h00;
  endfunction
endpackage

// [ineap_sync.sv]
// Two-flop synchroniser for signals arriving from outside the clock domain.
`timescale 1ns/1ps
module ineap_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input logic clk,
  input logic rst_n,
  input logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= RST;
      q <= RST;
    end else begin
      meta_ff <= d;
      q <= meta_ff;
    end
  end
endmodule

// [ineap_master.sv]
// I2C bus master model that drives the serial link of the block.
`timescale 1ns/1ps
module ineap_master (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Works from idle and as a repeated start with the clock low.
  task automatic start();
    sda_pull <= 1'b0;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b1;
    tick(4);
    scl <= 1'b0;
    tick(2);
  endtask

  task automatic bit_io(input logic b, output logic s);
    sda_pull <= !b;
    tick(2);
    scl <= 1'b1;
    tick(2);
    s = sda;
    tick(2);
    scl <= 1'b0;
    tick(2);
  endtask

  // Sends d most significant bit first, then drives ack_bit and returns the sampled bits.
  task automatic xbyte(input logic [7:0] d, input logic ack_bit, output logic [7:0] q, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(ack_bit, ack);
  endtask

  task automatic stop();
    sda_pull <= 1'b1;
    tick(2);
    scl <= 1'b1;
    tick(4);
    sda_pull <= 1'b0;
    tick(8);
  endtask
endmodule

// [i2c_nvm_erase_address_protect_bench.sv]
// Self-checking testbench of the I2C NVM erase and protection block.
`timescale 1ns/1ps
module i2c_nvm_erase_address_protect_bench;
  import ineap_pkg::*;
  logic mclk;
  logic reset_n;
  logic soft_reset;
  logic [3:0] pins;
  logic sda_out;
  logic sda_oe;
  logic nvm_busy;
  logic scl;
  logic sda_pull;
  wire sda = !(sda_pull || (sda_oe && !sda_out));
  logic [3:0] cc;
  logic [7:0] buf_d [16];
  logic [7:0] q;
  logic ack_c;
  logic ack_d;
  logic pre_busy;
  int num_errors;
  int n_compared;

  ineap_top #(.WR_CYC(1000)) ineap_top_i (.mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .ctrl_code_pins(pins), .soft_reset(soft_reset), .nvm_busy(nvm_busy));
  ineap_master ineap_master_i (.mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = !mclk;
  end

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] blk, input logic [7:0] word, input int n);
    ineap_master_i.start();
    ineap_master_i.xbyte({cc, blk, 1'b0}, 1'b1, q, ack_c);
    ineap_master_i.xbyte(word, 1'b1, q, ack_d);
    for (int i = 0; i < n; i++) begin
      ineap_master_i.xbyte(buf_d[i], 1'b1, q, ack_d);
    end
    pre_busy = nvm_busy;
    ineap_master_i.stop();
  endtask

  task automatic rd(input logic [2:0] blk, input logic [7:0] word, output logic [7:0] d);
    logic a;
    ineap_master_i.start();
    ineap_master_i.xbyte({cc, blk, 1'b0}, 1'b1, d, a);
    ineap_master_i.xbyte(word, 1'b1, d, a);
    ineap_master_i.start();
    ineap_master_i.xbyte({cc, blk, 1'b1}, 1'b1, d, ack_c);
    ineap_master_i.xbyte(8'hFF, 1'b1, d, a);
    ineap_master_i.stop();
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    while (nvm_busy !== 1'b0 && k < 1200) begin
      @(posedge mclk);
      k++;
    end
    chk({7'h0, nvm_busy}, 8'h00);
  endtask

  task automatic ers(input logic [7:0] v, input logic busy_exp);
    buf_d[0] = v;
    wr(BLK_REG, ERS_ADDR, 1);
    chk({7'h0, nvm_busy}, {7'h0, busy_exp});
    wait_idle();
  endtask

  initial begin
    repeat (80000) @(posedge mclk);
    num_errors++;
    summarize();
  end

  initial begin
    reset_n = 1'b0;
    soft_reset = 1'b0;
    pins = 4'hA;
    cc = 4'h1;
    num_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({6'h0, sda_oe, nvm_busy}, 8'h00);
    chk({7'h0, sda_out}, 8'h00);
    rd(BLK_REG, WPR_ADDR, q);
    chk(q, 8'h00);
    rd(BLK_REG, CODE_ADDR, q);
    chk({4'h0, q[3:0]}, 8'h01);
    $display("test defaults done");
    for (int b = 0; b < 8; b++) begin
      wr(3'(b), 8'h00, 0);
      chk({7'h0, ack_c}, {7'h0, b == 1 || b > 3});
      wait_idle();
    end
    cc = 4'h2;
    wr(BLK_REG, 8'h00, 0);
    chk({7'h0, ack_c}, 8'h01);
    cc = 4'h1;
    buf_d[0] = 8'hF0;
    wr(BLK_REG, CSEL_ADDR, 1);
    wr(BLK_REG, 8'h00, 0);
    chk({7'h0, ack_c}, 8'h01);
    cc = 4'hA;
    wr(BLK_REG, 8'h00, 0);
    chk({7'h0, ack_c}, 8'h00);
    buf_d[0] = 8'h00;
    wr(BLK_REG, CSEL_ADDR, 1);
    cc = 4'h1;
    wr(BLK_REG, 8'h00, 0);
    chk({7'h0, ack_c}, 8'h00);
    $display("test addressing done");
    for (int i = 0; i < 16; i++) buf_d[i] = {4'h3, 4'(i)};
    wr(BLK_EEP, 8'h50, 16);
    chk({7'h0, pre_busy}, 8'h00);
    chk({7'h0, nvm_busy}, 8'h01);
    rd(BLK_REG, WPR_ADDR, q);
    chk(q, 8'h00);
    chk({7'h0, ack_c}, 8'h00);
    // Page blocks refuse their control byte while the array cycle runs.
    wr(BLK_EEP, 8'h00, 0);
    chk({7'h0, ack_c}, 8'h01);
    chk({7'h0, nvm_busy}, 8'h01);
    wait_idle();
    for (int i = 0; i < 16; i++) buf_d[i] = 8'h05;
    wr(BLK_EEP, 8'h50, 16);
    wait_idle();
    for (int i = 0; i < 16; i++) begin
      rd(BLK_EEP, 8'h50 + 8'(i), q);
      chk(q, {4'h3, 4'(i)} | 8'h05);
    end
    $display("test program done");
    buf_d[0] = 8'h95;
    wr(BLK_REG, ERS_ADDR, 1);
    chk({6'h0, ack_c, ack_d}, 8'h01);
    chk({7'h0, nvm_busy}, 8'h01);
    wait_idle();
    rd(BLK_REG, ERS_ADDR, q);
    chk(q & 8'h80, 8'h00);
    rd(BLK_EEP, 8'h53, q);
    chk(q, 8'h00);
    $display("test erase done");
    for (int r = 0; r < 4; r++) begin
      buf_d[0] = 8'h04 | 8'(r);
      wr(BLK_REG, WPR_ADDR, 1);
      ers(8'h90 | 8'(12 - 4 * r), 1'b0);
      if (r < 3) ers(8'h90 | 8'(11 - 4 * r), 1'b1);
    end
    buf_d[0] = 8'h03;
    wr(BLK_REG, WPR_ADDR, 1);
    ers(8'h9F, 1'b1);
    ers(8'h8F, 1'b0);
    rd(BLK_CFG, 8'hF0, q);
    chk({7'h0, ack_c}, 8'h00);
    $display("test protection done");
    for (int i = 0; i < 16; i++) buf_d[i] = (i == 2) ? 8'h06 : 8'h00;
    wr(BLK_CFG, 8'hE0, 16);
    wait_idle();
    rd(BLK_REG, WPR_ADDR, q);
    chk(q, 8'h03);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    repeat (4) @(posedge mclk);
    rd(BLK_REG, WPR_ADDR, q);
    chk(q, 8'h06);
    // A configuration page erase while unlocked clears the stored protection image.
    ers(8'h8E, 1'b1);
    rd(BLK_CFG, 8'hE2, q);
    chk(q, 8'h00);
    buf_d[0] = 8'h01;
    wr(BLK_REG, LOCK_ADDR, 1);
    buf_d[0] = 8'h00;
    wr(BLK_REG, WPR_ADDR, 1);
    rd(BLK_REG, WPR_ADDR, q);
    chk(q, 8'h06);
    ers(8'h8E, 1'b0);
    $display("test lock done");
    summarize();
  end
endmodule
